//--- verilog/hpb_pkg.sv
package hpb_pkg;

   // Host address parity groups, as bit numbers of the A[35:3] vector.
   localparam int AP1_HI = 35;
   localparam int AP1_LO = 24;
   localparam int AP0_HI = 23;
   localparam int AP0_LO = 3;

   // Second request cycle layout on the address lines.
   localparam int BE_LSB     = 8;
   localparam int ID_LSB     = 16;
   localparam int DEFER_EN   = 27;
   localparam int ATTR_LSB   = 28;

   localparam int          DATA_W     = 64;
   localparam int          ECC_W      = 8;
   localparam int          BYTES      = 8;
   localparam logic [2:0]  BEATS_LINE = 3'h4;
   localparam logic [2:0]  BEATS_ONE  = 3'h1;

   // Each check bit covers the data bits selected by its mask.
   localparam logic [63:0] ECC_MASK [ECC_W] = '{
      64'hff00_00ff_0f0f_3355, 64'h00ff_ff00_f0f0_55aa, 64'h0f0f_0f0f_ff00_aa33,
      64'hf0f0_f0f0_00ff_33cc, 64'h3333_cccc_3333_ccf0, 64'hcccc_3333_cccc_330f,
      64'h5555_aaaa_aa55_5a5a, 64'haaaa_5555_55aa_a5a5};

   function automatic logic [1:0] addr_parity(input logic [35:3] a);
      addr_parity = {^a[AP1_HI:AP1_LO], ^a[AP0_HI:AP0_LO]};
   endfunction

   function automatic logic req_parity(input logic [4:0] r, input logic strobe);
      req_parity = ^{r, strobe};
   endfunction

   function automatic logic [7:0] ecc_gen(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < ECC_W; i++) begin
         c[i] = ^(d & ECC_MASK[i]);
      end
      ecc_gen = c;
   endfunction

   function automatic logic pci_parity(input logic [31:0] ad, input logic [3:0] cbe);
      pci_parity = ^{ad, cbe};
   endfunction

endpackage

//--- verilog/hpb_pci_parity.sv
`timescale 1ns/100ps
module hpb_pci_parity
   import hpb_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic [31:0] ad_in,
   input  wire logic [3:0]  cbe_in,
   input  wire logic        par_in,
   input  wire logic        drive_phase,
   input  wire logic        check_phase,
   input  wire logic        addr_phase,
   input  wire logic        perr_en,
   input  wire logic        serr_addr_en,
   input  wire logic        serr_data_en,
   output logic             par_o,
   output logic             par_oe,
   output logic             perr_o,
   output logic             serr_o
);

   logic exp_par_q, chk_q, adr_q, bad;

   assign bad = chk_q & (par_in != exp_par_q);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         exp_par_q <= 1'b0;
         chk_q     <= 1'b0;
         adr_q     <= 1'b0;
         par_o     <= 1'b0;
         par_oe    <= 1'b0;
         perr_o    <= 1'b0;
         serr_o    <= 1'b0;
      end else if (clk_en) begin
         exp_par_q <= pci_parity(ad_in, cbe_in);
         chk_q     <= check_phase;
         adr_q     <= addr_phase;
         par_o     <= pci_parity(ad_in, cbe_in);
         par_oe    <= drive_phase;
         perr_o    <= bad & ~adr_q & perr_en;
         serr_o    <= bad & (adr_q ? serr_addr_en : serr_data_en);
      end
   end

   a_par_even: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && drive_phase |=> par_oe && (par_o == $past(pci_parity(ad_in, cbe_in))))
      else $error("PAR is not even parity over the previous AD and C/BE.");

   a_perr_timing: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && check_phase && !addr_phase && perr_en ##1
      clk_en && (par_in != exp_par_q) |=> perr_o)
      else $error("PERR was not pulsed one clock after a bad PAR.");

endmodule // hpb_pci_parity

//--- verilog/hpb_sideband.sv
`timescale 1ns/100ps
module hpb_sideband
   import hpb_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic clk_en,
   input  wire logic buffer_flush_req,
   input  wire logic memory_access_req,
   input  wire logic posted_empty,
   input  wire logic all_empty,
   output logic      stop_posting,
   output logic      flush_all,
   output logic      guaranteed_latency_mode,
   output logic      memory_access_ack
);

   typedef enum logic [3:0] {
      SB_IDLE  = 4'b0001,
      SB_FLUSH = 4'b0010,
      SB_GAT   = 4'b0100,
      SB_ACK   = 4'b1000
   } hpb_sb_t;

   hpb_sb_t    st_q, st_d;
   logic [1:0] s1_q, s2_q;
   wire        flsh = s2_q[1];
   wire        mreq = s2_q[0];

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         SB_IDLE: begin
            if (flsh && mreq) st_d = SB_GAT;
            else if (flsh) st_d = SB_FLUSH;
         end
         SB_FLUSH: begin
            if (!flsh) st_d = SB_IDLE;
            else if (posted_empty) st_d = SB_ACK;
         end
         SB_GAT: begin
            if (!mreq) st_d = SB_IDLE;
            else if (all_empty) st_d = SB_ACK;
         end
         SB_ACK: begin
            if (!flsh || (guaranteed_latency_mode && !mreq)) st_d = SB_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q                    <= 2'h0;
         s2_q                    <= 2'h0;
         st_q                    <= SB_IDLE;
         stop_posting            <= 1'b0;
         flush_all               <= 1'b0;
         guaranteed_latency_mode <= 1'b0;
         memory_access_ack       <= 1'b0;
      end else if (clk_en) begin
         s1_q                    <= {buffer_flush_req, memory_access_req};
         s2_q                    <= s1_q;
         st_q                    <= st_d;
         stop_posting            <= (st_d != SB_IDLE);
         flush_all               <= (st_d == SB_GAT);
         guaranteed_latency_mode <= (st_d == SB_GAT) ||
                                    ((st_d == SB_ACK) && flsh && mreq);
         memory_access_ack       <= (st_d == SB_ACK);
      end
   end

   a_ack_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && memory_access_ack && flsh && mreq |=> memory_access_ack)
      else $error("Memory acknowledge dropped while both requests held.");

   a_ack_after_flush: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(memory_access_ack) |-> $past(posted_empty))
      else $error("Memory acknowledge rose before posted buffers emptied.");

   a_reserved_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && st_q == SB_IDLE && !flsh |=> st_q == SB_IDLE)
      else $error("Sideband left idle without a flush request.");

endmodule // hpb_sideband

//--- verilog/hpb_bridge.sv
`timescale 1ns/100ps
module hpb_bridge
   import hpb_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic         mreq_valid,
   input  wire logic [35:3]  mreq_addr,
   input  wire logic [4:0]   mreq_cmd,
   input  wire logic [4:0]   mreq_len,
   input  wire logic [7:0]   mreq_be,
   input  wire logic [7:0]   mreq_id,
   input  wire logic [3:0]   mreq_attr,
   input  wire logic         mreq_line,
   input  wire logic         mreq_write,
   input  wire logic [255:0] mreq_wline,
   output logic              mreq_ready,
   input  wire logic         host_trdy,
   output logic              host_req_oe,
   output logic              request_strobe,
   output logic [35:3]       host_addr_o,
   output logic [1:0]        addr_parity_bits,
   output logic [4:0]        host_req_o,
   output logic              request_parity_line,
   output logic              host_data_oe,
   output logic [63:0]       host_data_o,
   output logic [7:0]        data_check_bits,
   output logic              data_valid_line,
   output logic              data_hold_line,
   input  wire logic         host_strobe_in,
   input  wire logic [35:3]  host_addr_in,
   input  wire logic [1:0]   host_ap_in,
   input  wire logic [4:0]   host_req_in,
   input  wire logic         host_rp_in,
   input  wire logic         addr_error_line_en,
   input  wire logic         bus_error_line_en,
   output logic              addr_error_line,
   output logic              bus_error_line,
   input  wire logic         snoop_pci_target,
   input  wire logic         snoop_stall,
   output logic              snoop_hit_line,
   output logic              snoop_modified_line,
   input  wire logic         bus_reinit_line,
   output logic              pci_terminate,
   output logic              queue_reset,
   input  wire logic         cache_flush_cmd,
   output logic              cache_flush_out,
   input  wire logic         sysmgmt_ack_cycle,
   input  wire logic         sysmgmt_space_flag,
   output logic              sysmgmt_ack_out,
   input  wire logic         buffer_flush_req,
   input  wire logic         memory_access_req,
   input  wire logic         posted_empty,
   input  wire logic         all_empty,
   output logic              stop_posting,
   output logic              flush_all,
   output logic              guaranteed_latency_mode,
   output logic              memory_access_ack,
   input  wire logic [31:0]  pci_ad_in,
   input  wire logic [3:0]   pci_cbe_in,
   input  wire logic         pci_par_in,
   input  wire logic         pci_drive_phase,
   input  wire logic         pci_check_phase,
   input  wire logic         pci_addr_phase,
   input  wire logic         perr_en,
   input  wire logic         serr_addr_en,
   input  wire logic         serr_data_en,
   output logic              pci_par_o,
   output logic              pci_par_oe,
   output logic              pci_perr,
   output logic              pci_serr,
   input  wire logic         dual_bridge,
   input  wire logic         primary_bridge,
   input  wire logic         bridge_request_in,
   input  wire logic         bridge_grant_in,
   output logic              bridge_grant_line,
   output logic              bridge_grant_oe,
   output logic              bridge_request_out,
   output logic [1:0]        bridge_id
);

   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_REQA = 4'b0010,
      HS_REQB = 4'b0100,
      HS_DATA = 4'b1000
   } hpb_hst_t;

   hpb_hst_t     st_q, st_d;
   logic [255:0] line_q;
   logic [2:0]   left_q;
   logic         write_q, line_mode_q, strap_done_q, rx_b_q;
   logic [7:0]   be_q, id_q;
   logic [3:0]   attr_q;
   logic [4:0]   len_q;
   logic [35:3]  attr_word;
   logic [63:0]  beat_data;

   // The secondary bridge issues only while granted; the primary stops while granting.
   wire host_owned = !dual_bridge || (primary_bridge ? !bridge_grant_line : bridge_grant_in);
   wire start      = mreq_valid && mreq_ready && host_owned;
   wire beat_go    = (st_q == HS_DATA) && host_trdy;
   wire last_beat  = (left_q == BEATS_ONE);

   // Second request cycle: byte enables, id and attributes; defer enable held low.
   always_comb begin
      attr_word                           = 33'h0;
      attr_word[BE_LSB +: BYTES]          = be_q;
      attr_word[ID_LSB +: 8]              = id_q;
      attr_word[ATTR_LSB +: 4]            = attr_q;
      attr_word[DEFER_EN]                 = 1'b0;
   end

   // Partial transfers zero the disabled bytes before the check bits are formed.
   always_comb begin
      beat_data = line_q[DATA_W-1:0];
      for (int b = 0; b < BYTES; b++) begin
         if (!line_mode_q && !be_q[b]) beat_data[b*8 +: 8] = 8'h00;
      end
   end

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         HS_IDLE: if (start) st_d = HS_REQA;
         HS_REQA: st_d = HS_REQB;
         HS_REQB: st_d = write_q ? HS_DATA : HS_IDLE;
         HS_DATA: if (beat_go && last_beat) st_d = HS_IDLE;
      endcase
      if (bus_reinit_line) st_d = HS_IDLE;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q        <= HS_IDLE;
         line_q      <= 256'h0;
         left_q      <= 3'h0;
         write_q     <= 1'b0;
         line_mode_q <= 1'b0;
         be_q        <= 8'h00;
         id_q        <= 8'h00;
         attr_q      <= 4'h0;
         len_q       <= 5'h00;
      end else if (clk_en) begin
         st_q <= st_d;
         if (start) begin
            line_q      <= mreq_wline;
            write_q     <= mreq_write;
            line_mode_q <= mreq_line;
            be_q        <= mreq_line ? 8'hff : mreq_be;
            id_q        <= mreq_id;
            attr_q      <= mreq_attr;
            len_q       <= mreq_len;
            left_q      <= mreq_line ? BEATS_LINE : BEATS_ONE;
         end else if (beat_go) begin
            line_q <= {64'h0, line_q[255:DATA_W]};
            left_q <= left_q - 3'h1;
         end
      end
   end

   // Request group pins, both request cycles.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_req_oe         <= 1'b0;
         request_strobe      <= 1'b0;
         host_addr_o         <= 33'h0;
         addr_parity_bits    <= 2'h0;
         host_req_o          <= 5'h00;
         request_parity_line <= 1'b0;
         mreq_ready          <= 1'b0;
      end else if (clk_en) begin
         mreq_ready  <= (st_d == HS_IDLE) && !flush_all && !bus_reinit_line;
         host_req_oe <= (st_d == HS_REQA) || (st_d == HS_REQB);
         if (st_d == HS_REQA) begin
            request_strobe      <= 1'b1;
            host_addr_o         <= mreq_addr;
            addr_parity_bits    <= addr_parity(mreq_addr);
            host_req_o          <= mreq_cmd;
            request_parity_line <= req_parity(mreq_cmd, 1'b1);
         end else if (st_d == HS_REQB) begin
            request_strobe      <= 1'b0;
            host_addr_o         <= attr_word;
            addr_parity_bits    <= addr_parity(attr_word);
            host_req_o          <= len_q;
            request_parity_line <= req_parity(len_q, 1'b0);
         end else begin
            request_strobe      <= 1'b0;
         end
      end
   end

   // Data group pins.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_data_oe    <= 1'b0;
         host_data_o     <= 64'h0;
         data_check_bits <= 8'h00;
         data_valid_line <= 1'b0;
         data_hold_line  <= 1'b0;
      end else if (clk_en) begin
         host_data_oe    <= beat_go;
         host_data_o     <= beat_data;
         data_check_bits <= ecc_gen(beat_data);
         data_valid_line <= beat_go;
         data_hold_line  <= beat_go && !last_beat;
      end
   end

   // Checking of requests seen on the host bus, in both request cycles.
   wire ap_bad = (addr_parity(host_addr_in) != host_ap_in);
   wire rp_bad = (req_parity(host_req_in, host_strobe_in) != host_rp_in);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_b_q              <= 1'b0;
         addr_error_line     <= 1'b0;
         bus_error_line      <= 1'b0;
         snoop_hit_line      <= 1'b0;
         snoop_modified_line <= 1'b0;
         pci_terminate       <= 1'b0;
         queue_reset         <= 1'b0;
         cache_flush_out     <= 1'b0;
         sysmgmt_ack_out     <= 1'b0;
      end else if (clk_en) begin
         rx_b_q              <= host_strobe_in;
         addr_error_line     <= addr_error_line_en && (host_strobe_in || rx_b_q) && (ap_bad || rp_bad);
         bus_error_line      <= bus_error_line_en && host_strobe_in && rx_b_q;
         snoop_hit_line      <= snoop_pci_target && snoop_stall;
         snoop_modified_line <= snoop_pci_target && snoop_stall;
         pci_terminate       <= bus_reinit_line;
         queue_reset         <= bus_reinit_line;
         cache_flush_out     <= cache_flush_cmd;
         if (sysmgmt_ack_cycle) begin
            sysmgmt_ack_out <= sysmgmt_space_flag;
         end
      end
   end

   // Bridge arbitration and the reset strap.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_done_q       <= 1'b0;
         bridge_id          <= 2'h0;
         bridge_grant_line  <= 1'b0;
         bridge_grant_oe    <= 1'b0;
         bridge_request_out <= 1'b0;
      end else if (clk_en) begin
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            bridge_id    <= {bridge_grant_in, bridge_request_in};
         end
         bridge_grant_oe    <= strap_done_q && dual_bridge && primary_bridge;
         bridge_grant_line  <= strap_done_q && dual_bridge && primary_bridge &&
                               bridge_request_in && (st_d == HS_IDLE);
         bridge_request_out <= strap_done_q && dual_bridge && !primary_bridge &&
                               mreq_valid;
      end
   end

   hpb_sideband u_sideband (
      .sys_clk                 (sys_clk),
      .rst_b                   (rst_b),
      .clk_en                  (clk_en),
      .buffer_flush_req        (buffer_flush_req),
      .memory_access_req       (memory_access_req),
      .posted_empty            (posted_empty),
      .all_empty               (all_empty),
      .stop_posting            (stop_posting),
      .flush_all               (flush_all),
      .guaranteed_latency_mode (guaranteed_latency_mode),
      .memory_access_ack       (memory_access_ack)
   );

   hpb_pci_parity u_pci_parity (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .ad_in        (pci_ad_in),
      .cbe_in       (pci_cbe_in),
      .par_in       (pci_par_in),
      .drive_phase  (pci_drive_phase),
      .check_phase  (pci_check_phase),
      .addr_phase   (pci_addr_phase),
      .perr_en      (perr_en),
      .serr_addr_en (serr_addr_en),
      .serr_data_en (serr_data_en),
      .par_o        (pci_par_o),
      .par_oe       (pci_par_oe),
      .perr_o       (pci_perr),
      .serr_o       (pci_serr)
   );

   sequence s_req_pair;
      request_strobe ##1 (host_req_oe && !request_strobe);
   endsequence

   a_req_second: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && request_strobe && !bus_reinit_line |=> host_req_oe && !request_strobe)
      else $error("Request strobe not followed by the second request cycle.");

   a_defer_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_req_pair |-> !host_addr_o[DEFER_EN])
      else $error("Defer enable set in the bridge's own request.");

   a_ap_valid: assert property (@(posedge sys_clk) disable iff (!rst_b)
      host_req_oe |-> addr_parity_bits == addr_parity(host_addr_o))
      else $error("Address parity wrong during a request cycle.");

   a_rp_valid: assert property (@(posedge sys_clk) disable iff (!rst_b)
      host_req_oe |-> request_parity_line == req_parity(host_req_o, request_strobe))
      else $error("Request parity wrong during a request cycle.");

   a_hold_next: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && data_hold_line |=> data_valid_line || !$past(host_trdy) || !host_trdy)
      else $error("Data hold asserted with no following data beat.");

   a_valid_ecc: assert property (@(posedge sys_clk) disable iff (!rst_b)
      data_valid_line |-> host_data_oe && data_check_bits == ecc_gen(host_data_o))
      else $error("Data valid beat with wrong check bits.");

   a_snoop_pair: assert property (@(posedge sys_clk) disable iff (!rst_b)
      snoop_hit_line == snoop_modified_line)
      else $error("Snoop hit and snoop modified differ.");

   a_smi_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && sysmgmt_ack_cycle && !sysmgmt_space_flag |=> !sysmgmt_ack_out)
      else $error("Management acknowledge not cleared by its special cycle.");

   a_reinit_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && bus_reinit_line |=> queue_reset && pci_terminate && st_q == HS_IDLE)
      else $error("Bus reinit did not reset the queues.");

endmodule // hpb_bridge

//--- verif/hpb_host_tgt.sv
`timescale 1ns/100ps
module hpb_host_tgt
   import hpb_pkg::*;
#(
   parameter int STALL = 2
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   output logic      host_trdy
);
   // Ready comes at random, so the data phase sees both prompt and stalled beats.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_trdy <= 1'b0;
      end else begin
         host_trdy <= ($urandom_range(STALL) == 0);
      end
   end
endmodule // hpb_host_tgt

//--- verif/hpb_bridge_tb.sv
`timescale 1ns/100ps
module hpb_bridge_tb
   import hpb_pkg::*;
;
   logic sys_clk, rst_b, clk_en, mreq_valid, mreq_line, mreq_write, mreq_ready, host_trdy;
   logic host_req_oe, request_strobe, request_parity_line, host_data_oe, data_valid_line;
   logic data_hold_line, host_strobe_in, host_rp_in, addr_error_line_en, bus_error_line_en, addr_error_line;
   logic bus_error_line, snoop_pci_target, snoop_stall, snoop_hit_line, snoop_modified_line;
   logic bus_reinit_line, pci_terminate, queue_reset, cache_flush_cmd, cache_flush_out;
   logic sysmgmt_ack_cycle, sysmgmt_space_flag, sysmgmt_ack_out, buffer_flush_req;
   logic memory_access_req, posted_empty, all_empty, stop_posting, flush_all;
   logic guaranteed_latency_mode, memory_access_ack, pci_par_in, pci_drive_phase;
   logic pci_check_phase, pci_addr_phase, perr_en, serr_addr_en, serr_data_en, pci_par_o;
   logic pci_par_oe, pci_perr, pci_serr, dual_bridge, primary_bridge, bridge_request_in;
   logic bridge_grant_in, bridge_grant_line, bridge_grant_oe, bridge_request_out;
   logic [35:3]  mreq_addr, host_addr_o, host_addr_in;
   logic [4:0]   mreq_cmd, mreq_len, host_req_o, host_req_in;
   logic [7:0]   mreq_be, mreq_id, data_check_bits, bx;
   logic [3:0]   mreq_attr, pci_cbe_in;
   logic [1:0]   addr_parity_bits, host_ap_in, bridge_id, pe, ps, apx;
   logic [63:0]  host_data_o;
   logic [255:0] mreq_wline;
   logic [31:0]  pci_ad_in;
   logic         pd, pp, cf, rl, sm, e, sn;
   int           failures, tests_run, nb;
   // The bridge watches its own request pins; apx flips the address parity it sees, injecting a receive error on pass 3.
   assign {host_strobe_in, host_addr_in, host_ap_in, host_req_in, host_rp_in} =
      {request_strobe, host_addr_o, addr_parity_bits ^ apx, host_req_o, request_parity_line};
   hpb_bridge hpb_bridge_i (.*);
   hpb_host_tgt #(.STALL(2)) hpb_host_tgt_i (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   // Expected beat: disabled bytes zeroed, check bits formed from the package masks.
   function automatic logic [71:0] exp_beat(input logic [63:0] d, input logic [7:0] be);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 0; b < BYTES; b++) begin
         if (!be[b]) d[b*8+:8] = 8'h00;
      end
      for (int j = 0; j < ECC_W; j++) begin
         c[j] = ^(d & ECC_MASK[j]);
      end
      return {c, d};
   endfunction
   task automatic end_of_test();
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int n = 0; s !== v; n++) begin
         if (n > 40) begin
            failures++;
            end_of_test();
         end
         @(negedge sys_clk);
      end
   endtask
   task automatic sb(input logic [3:0] fm, ref logic s, input logic v);
      @(posedge sys_clk);
      {buffer_flush_req, memory_access_req, posted_empty, all_empty} <= fm;
      @(negedge sys_clk);
      wait_for(s, v);
   endtask
   initial begin
      {rst_b, mreq_valid, mreq_addr, mreq_cmd, mreq_len, mreq_be, mreq_id, mreq_attr, mreq_line,
       mreq_write, mreq_wline, snoop_pci_target, snoop_stall, bus_reinit_line, cache_flush_cmd,
       sysmgmt_ack_cycle, sysmgmt_space_flag, buffer_flush_req, memory_access_req, posted_empty,
       all_empty, pci_ad_in, pci_cbe_in, pci_par_in, pci_drive_phase, pci_check_phase,
       pci_addr_phase, dual_bridge, primary_bridge, bridge_grant_in, pe, ps, pd, pp, cf, rl,
       sm, sn, apx} = '0;
      {clk_en, addr_error_line_en, bus_error_line_en, perr_en, serr_addr_en, serr_data_en, bridge_request_in} = '1;
      void'($urandom(12160));
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(negedge sys_clk);
      chk({bridge_id, bridge_grant_oe, bridge_request_out}, 4'b0100);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         {mreq_addr, mreq_cmd, mreq_len} <= 43'({$urandom, $urandom});
         {mreq_be, mreq_id, mreq_attr} <= 20'($urandom);
         mreq_wline <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
         {mreq_line, mreq_write, mreq_valid} <= {i[0], i < 6, 1'b1};
         @(negedge sys_clk);
         wait_for(mreq_ready, 1'b1);
         @(posedge sys_clk);
         mreq_valid <= 1'b0;
         apx <= 2'(i == 3);
         @(negedge sys_clk);
         bx = mreq_line ? 8'hff : mreq_be;
         chk({request_strobe, host_req_oe, host_addr_o}, {2'b11, mreq_addr});
         chk(addr_parity_bits, {^mreq_addr[35:24], ^mreq_addr[23:3]});
         chk(request_parity_line, ^{mreq_cmd, 1'b1});
         @(negedge sys_clk);
         chk({host_addr_o[DEFER_EN], host_addr_o[BE_LSB+:8]}, {1'b0, bx});
         chk({host_addr_o[ID_LSB+:8], host_addr_o[ATTR_LSB+:4]}, {mreq_id, mreq_attr});
         chk(addr_parity_bits, {^host_addr_o[35:24], ^host_addr_o[23:3]});
         chk({request_parity_line, host_req_o}, {^mreq_len, mreq_len});
         chk({addr_error_line, bus_error_line}, {i == 3, 1'b0});
         nb = 0;
         for (int k = 0; k < 60 && mreq_write && nb < (mreq_line ? 4 : 1); k++) begin
            @(negedge sys_clk);
            if (data_valid_line === 1'b1) begin
               chk({data_check_bits, host_data_o}, exp_beat(mreq_wline[nb*64+:64], bx));
               chk({data_hold_line, host_data_oe}, {nb < (mreq_line ? 3 : 0), 1'b1});
               nb++;
            end
         end
         chk(nb, mreq_write ? (mreq_line ? 4 : 1) : 0);
      end
      sb(4'b1000, stop_posting, 1'b1);
      chk({memory_access_ack, guaranteed_latency_mode}, 2'b00);
      sb(4'b1010, memory_access_ack, 1'b1);
      sb(4'b0010, memory_access_ack, 1'b0);
      sb(4'b0111, stop_posting, 1'b0);
      repeat (6) @(negedge sys_clk);
      chk({memory_access_ack, guaranteed_latency_mode, flush_all}, 3'b000);
      sb(4'b1110, guaranteed_latency_mode, 1'b1);
      chk({flush_all, memory_access_ack}, 2'b10);
      sb(4'b1111, memory_access_ack, 1'b1);
      sb(4'b0011, memory_access_ack, 1'b0);
      for (int k = 0; k < 48; k++) begin
         @(posedge sys_clk);
         e = ($urandom_range(3) == 0);
         pe = {pe[0], e & pci_check_phase & ~pci_addr_phase};
         ps = {ps[0], e & pci_check_phase};
         pci_par_in <= ^{pci_ad_in, pci_cbe_in} ^ e;
         {pci_ad_in, pci_cbe_in, pci_addr_phase} <= 37'({$urandom, $urandom});
         {pci_drive_phase, pci_check_phase, bus_reinit_line} <= {k < 24, k >= 24, k == 46};
         {cache_flush_cmd, snoop_pci_target, snoop_stall} <= 3'($urandom);
         {sysmgmt_ack_cycle, sysmgmt_space_flag} <= 2'($urandom);
         @(negedge sys_clk);
         chk({pci_par_oe, cache_flush_out, pci_perr, pci_serr, sysmgmt_ack_out, pci_terminate,
              queue_reset, snoop_hit_line, snoop_modified_line},
             {pd, cf, pe[1], ps[1], sm, rl, rl, sn, sn});
         if (pd) chk(pci_par_o, pp);
         if (sysmgmt_ack_cycle) sm = sysmgmt_space_flag;
         {pd, cf, rl} = {pci_drive_phase, cache_flush_cmd, bus_reinit_line};
         sn = snoop_pci_target & snoop_stall;
         pp = ^{pci_ad_in, pci_cbe_in};
      end
      end_of_test();
   end
endmodule // hpb_bridge_tb
